// ---- hpbac_defines.svh ----
// Constants for the hub-to-PCI bridge abort and decode control block
`ifndef HPBAC_DEFINES_SVH
`define HPBAC_DEFINES_SVH
`define HPBAC_CTRL_W 8
`define HPBAC_CTRL_RESET 8'h00
`define HPBAC_CTRL_MASK 8'h3E
`define HPBAC_BIT_SYS_ERR_REPORT 1
`define HPBAC_BIT_ISA_EN 2
`define HPBAC_BIT_VGA_EN 3
`define HPBAC_BIT_VGA16 4
`define HPBAC_BIT_ABORT_MODE 5
`define HPBAC_PCMD_SERR_BIT 8
`define HPBAC_PSTS_SIG_ERR_BIT 14
`define HPBAC_PSTS_OFFSET 8'h06
`define HPBAC_PSTS_RESET 16'h0000
`define HPBAC_VGA_MEM_LO 32'h000A_0000
`define HPBAC_VGA_MEM_HI 32'h000B_FFFF
`define HPBAC_VGA_IO_LO1 32'h0000_03B0
`define HPBAC_VGA_IO_HI1 32'h0000_03BB
`define HPBAC_VGA_IO_LO2 32'h0000_03C0
`define HPBAC_VGA_IO_HI2 32'h0000_03DF
`define HPBAC_ABORT_DATA 32'hFFFF_FFFF
`define HPBAC_ZERO_DATA 32'h0000_0000
`endif

// ---- hpbac_pkg.sv ----
// Types for the hub-to-PCI bridge abort and decode control block
package hpbac_pkg;
  typedef enum logic [1:0] {
    HPBAC_CMPL_OK = 2'b00,
    HPBAC_CMPL_MASTER_ABORT = 2'b01,
    HPBAC_CMPL_TARGET_ABORT = 2'b10
  } hpbac_cmpl_e;
  typedef enum logic [1:0] {
    HPBAC_UP_IDLE = 2'b00,
    HPBAC_UP_WAIT = 2'b01
  } hpbac_up_state_e;
  typedef enum logic [1:0] {
    HPBAC_DN_IDLE = 2'b00,
    HPBAC_DN_WAIT = 2'b01
  } hpbac_dn_state_e;
endpackage

// ---- hpbac_decode.sv ----
// Address claim and forwarding decode for PCI and hub cycles
`timescale 1ns/1ps
`include "hpbac_defines.svh"
module hpbac_decode (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic vga_en_in,
  input wire logic [31:0] pci_addr_in,
  input wire logic pci_mem_cycle_in,
  input wire logic pci_io_cycle_in,
  input wire logic pci_io_target_hit_in,
  input wire logic hub_io_cycle_in,
  input wire logic usb_io_hit_in,
  input wire logic audio_io_hit_in,
  input wire logic ide_io_hit_in,
  output logic pci_mem_claim_out,
  output logic pci_io_claim_out,
  output logic hub_io_to_pci_out
);
  logic mem_claim_q, mem_claim_d;
  logic io_claim_q, io_claim_d;
  logic io_fwd_q, io_fwd_d;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    // Legacy window belongs to the PCI graphics device when enabled
    mem_claim_d = pci_mem_cycle_in &&
      !(vga_en_in && in_range(pci_addr_in, `HPBAC_VGA_MEM_LO, `HPBAC_VGA_MEM_HI));
    // VGA ports stay on PCI regardless of any enable
    io_claim_d = pci_io_cycle_in && pci_io_target_hit_in &&
      !in_range(pci_addr_in, `HPBAC_VGA_IO_LO1, `HPBAC_VGA_IO_HI1) &&
      !in_range(pci_addr_in, `HPBAC_VGA_IO_LO2, `HPBAC_VGA_IO_HI2);
    io_fwd_d = hub_io_cycle_in && !usb_io_hit_in && !audio_io_hit_in && !ide_io_hit_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_claim_q <= 1'b0;
      io_claim_q <= 1'b0;
      io_fwd_q <= 1'b0;
    end else begin
      mem_claim_q <= mem_claim_d;
      io_claim_q <= io_claim_d;
      io_fwd_q <= io_fwd_d;
    end
  end

  assign pci_mem_claim_out = mem_claim_q;
  assign pci_io_claim_out = io_claim_q;
  assign hub_io_to_pci_out = io_fwd_q;
endmodule

// ---- hpbac_up_read.sv ----
// PCI read forwarded to the hub: data return and abort handling
`timescale 1ns/1ps
`include "hpbac_defines.svh"
module hpbac_up_read (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic abort_mode_in,
  input wire logic up_rd_start_in,
  input wire logic hub_rd_valid_in,
  input wire logic hub_rd_last_in,
  input wire logic [31:0] hub_rd_data_in,
  input wire logic hub_master_abort_in,
  input wire logic [31:0] hub_abort_data_in,
  output logic pci_rd_valid_out,
  output logic [31:0] pci_rd_data_out,
  output logic pci_target_abort_out,
  output logic prefetch_flush_out,
  output logic up_rd_busy_out
);
  hpbac_pkg::hpbac_up_state_e state_q, state_d;
  logic mode_q, mode_d;
  logic valid_q, valid_d;
  logic [31:0] data_q, data_d;
  logic tabort_q, tabort_d;
  logic flush_q, flush_d;

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    valid_d = 1'b0;
    data_d = data_q;
    tabort_d = 1'b0;
    flush_d = 1'b0;
    case (state_q)
      hpbac_pkg::HPBAC_UP_IDLE: begin
        if (up_rd_start_in) begin
          // Mode frozen per transaction
          mode_d = abort_mode_in;
          state_d = hpbac_pkg::HPBAC_UP_WAIT;
        end
      end
      hpbac_pkg::HPBAC_UP_WAIT: begin
        if (hub_master_abort_in) begin
          state_d = hpbac_pkg::HPBAC_UP_IDLE;
          if (mode_q) begin
            tabort_d = 1'b1;
            flush_d = 1'b1;
          end else begin
            valid_d = 1'b1;
            data_d = hub_abort_data_in;
          end
        end else if (hub_rd_valid_in) begin
          valid_d = 1'b1;
          data_d = hub_rd_data_in;
          if (hub_rd_last_in) begin
            state_d = hpbac_pkg::HPBAC_UP_IDLE;
          end
        end
      end
      default: begin
        state_d = hpbac_pkg::HPBAC_UP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= hpbac_pkg::HPBAC_UP_IDLE;
      mode_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= `HPBAC_ZERO_DATA;
      tabort_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      valid_q <= valid_d;
      data_q <= data_d;
      tabort_q <= tabort_d;
      flush_q <= flush_d;
    end
  end

  assign pci_rd_valid_out = valid_q;
  assign pci_rd_data_out = data_q;
  assign pci_target_abort_out = tabort_q;
  assign prefetch_flush_out = flush_q;
  assign up_rd_busy_out = (state_q != hpbac_pkg::HPBAC_UP_IDLE);
endmodule

// ---- hpbac_top.sv ----
// Hub-to-PCI bridge abort handling, decode control bits and system error path
`timescale 1ns/1ps
`include "hpbac_defines.svh"
module hpbac_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ctrl_wr_in,
  input wire logic [7:0] ctrl_wdata_in,
  output logic [7:0] ctrl_rdata_out,
  input wire logic [15:0] primary_cmd_in,
  input wire logic sig_err_flag_clr_in,
  output logic [15:0] primary_device_status_out,
  input wire logic pci_serr_n_in,
  input wire logic nmi_to_sysmgmt_in,
  output logic nmi_out,
  output logic system_management_interrupt_out,
  input wire logic hub_req_start_in,
  input wire logic hub_req_posted_in,
  input wire logic hub_req_read_in,
  input wire logic pci_cycle_done_in,
  input wire logic pci_master_abort_in,
  input wire logic [31:0] pci_rd_data_in,
  output logic hub_cmpl_valid_out,
  output logic [1:0] hub_cmpl_status_out,
  output logic [31:0] hub_cmpl_data_out,
  output logic posted_drop_out,
  output logic dn_busy_out,
  input wire logic up_rd_start_in,
  input wire logic hub_rd_valid_in,
  input wire logic hub_rd_last_in,
  input wire logic [31:0] hub_rd_data_in,
  input wire logic hub_master_abort_in,
  input wire logic [31:0] hub_abort_data_in,
  output logic pci_rd_valid_out,
  output logic [31:0] pci_rd_data_out,
  output logic pci_target_abort_out,
  output logic prefetch_flush_out,
  output logic up_rd_busy_out,
  input wire logic [31:0] pci_addr_in,
  input wire logic pci_mem_cycle_in,
  input wire logic pci_io_cycle_in,
  input wire logic pci_io_target_hit_in,
  input wire logic hub_io_cycle_in,
  input wire logic usb_io_hit_in,
  input wire logic audio_io_hit_in,
  input wire logic ide_io_hit_in,
  output logic pci_mem_claim_out,
  output logic pci_io_claim_out,
  output logic hub_io_to_pci_out
);
  // Control bits
  logic [7:0] ctrl_q, ctrl_d;
  logic abort_mode;
  logic vga_en;
  logic serr_report_en;
  logic serr_path_en;

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr_in) begin
      // Storage only for bits 1 to 5; bit 0 and bits 7:6 always read as zero
      ctrl_d = ctrl_wdata_in & `HPBAC_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_q <= `HPBAC_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl_rdata_out = ctrl_q;
  assign abort_mode = ctrl_q[`HPBAC_BIT_ABORT_MODE];
  assign vga_en = ctrl_q[`HPBAC_BIT_VGA_EN];
  assign serr_report_en = ctrl_q[`HPBAC_BIT_SYS_ERR_REPORT];
  assign serr_path_en = serr_report_en && primary_cmd_in[`HPBAC_PCMD_SERR_BIT];

  // System error pin synchroniser, active low pin
  // Only the second flop is read; the first may go metastable
  logic serr_meta_q, serr_meta_d;
  logic serr_sync_q, serr_sync_d;
  logic serr_prev_q, serr_prev_d;
  logic serr_rise;

  always_comb begin
    serr_meta_d = ~pci_serr_n_in;
    serr_sync_d = serr_meta_q;
    serr_prev_d = serr_sync_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serr_meta_q <= 1'b0;
      serr_sync_q <= 1'b0;
      serr_prev_q <= 1'b0;
    end else begin
      serr_meta_q <= serr_meta_d;
      serr_sync_q <= serr_sync_d;
      serr_prev_q <= serr_prev_d;
    end
  end

  // One event per assertion, not per cycle held
  assign serr_rise = serr_sync_q && !serr_prev_q;

  // One qualified event feeds both the interrupt and the flag
  logic serr_event;
  assign serr_event = serr_rise && serr_path_en;

  // Interrupt pulses
  logic nmi_q, nmi_d;
  logic sysmgmt_q, sysmgmt_d;

  always_comb begin
    // Route picks exactly one destination per event
    nmi_d = serr_event && !nmi_to_sysmgmt_in;
    sysmgmt_d = serr_event && nmi_to_sysmgmt_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nmi_q <= 1'b0;
      sysmgmt_q <= 1'b0;
    end else begin
      nmi_q <= nmi_d;
      sysmgmt_q <= sysmgmt_d;
    end
  end

  assign nmi_out = nmi_q;
  assign system_management_interrupt_out = sysmgmt_q;

  // Hub request forwarded to PCI
  hpbac_pkg::hpbac_dn_state_e dn_state_q, dn_state_d;
  logic dn_mode_q, dn_mode_d;
  logic dn_posted_q, dn_posted_d;
  logic dn_read_q, dn_read_d;
  logic cmpl_valid_q, cmpl_valid_d;
  logic [1:0] cmpl_status_q, cmpl_status_d;
  logic [31:0] cmpl_data_q, cmpl_data_d;
  logic drop_q, drop_d;
  logic posted_flag_set;

  always_comb begin
    dn_state_d = dn_state_q;
    dn_mode_d = dn_mode_q;
    dn_posted_d = dn_posted_q;
    dn_read_d = dn_read_q;
    cmpl_valid_d = 1'b0;
    cmpl_status_d = cmpl_status_q;
    cmpl_data_d = cmpl_data_q;
    drop_d = 1'b0;
    posted_flag_set = 1'b0;
    case (dn_state_q)
      hpbac_pkg::HPBAC_DN_IDLE: begin
        if (hub_req_start_in) begin
          // Mode taken at start so a mid-flight write cannot change it
          dn_mode_d = abort_mode;
          dn_posted_d = hub_req_posted_in;
          dn_read_d = hub_req_read_in && !hub_req_posted_in;
          dn_state_d = hpbac_pkg::HPBAC_DN_WAIT;
        end
      end
      hpbac_pkg::HPBAC_DN_WAIT: begin
        if (pci_master_abort_in) begin
          dn_state_d = hpbac_pkg::HPBAC_DN_IDLE;
          if (dn_posted_q) begin
            drop_d = 1'b1;
            posted_flag_set = dn_mode_q && serr_report_en;
          end else begin
            cmpl_valid_d = 1'b1;
            cmpl_status_d = dn_mode_q ? hpbac_pkg::HPBAC_CMPL_TARGET_ABORT
                                      : hpbac_pkg::HPBAC_CMPL_MASTER_ABORT;
            cmpl_data_d = dn_read_q ? `HPBAC_ABORT_DATA : `HPBAC_ZERO_DATA;
          end
        end else if (pci_cycle_done_in) begin
          dn_state_d = hpbac_pkg::HPBAC_DN_IDLE;
          // Posted writes have no waiting requester, so no completion
          if (!dn_posted_q) begin
            cmpl_valid_d = 1'b1;
            cmpl_status_d = hpbac_pkg::HPBAC_CMPL_OK;
            cmpl_data_d = dn_read_q ? pci_rd_data_in : `HPBAC_ZERO_DATA;
          end
        end
      end
      default: begin
        dn_state_d = hpbac_pkg::HPBAC_DN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dn_state_q <= hpbac_pkg::HPBAC_DN_IDLE;
      dn_mode_q <= 1'b0;
      dn_posted_q <= 1'b0;
      dn_read_q <= 1'b0;
      cmpl_valid_q <= 1'b0;
      cmpl_status_q <= hpbac_pkg::HPBAC_CMPL_OK;
      cmpl_data_q <= `HPBAC_ZERO_DATA;
      drop_q <= 1'b0;
    end else begin
      dn_state_q <= dn_state_d;
      dn_mode_q <= dn_mode_d;
      dn_posted_q <= dn_posted_d;
      dn_read_q <= dn_read_d;
      cmpl_valid_q <= cmpl_valid_d;
      cmpl_status_q <= cmpl_status_d;
      cmpl_data_q <= cmpl_data_d;
      drop_q <= drop_d;
    end
  end

  assign hub_cmpl_valid_out = cmpl_valid_q;
  assign hub_cmpl_status_out = cmpl_status_q;
  assign hub_cmpl_data_out = cmpl_data_q;
  assign posted_drop_out = drop_q;
  assign dn_busy_out = (dn_state_q != hpbac_pkg::HPBAC_DN_IDLE);

  // Signaled system error status flag
  logic sig_err_q, sig_err_d;

  always_comb begin
    sig_err_d = sig_err_q;
    if (sig_err_flag_clr_in) begin
      sig_err_d = 1'b0;
    end
    // Set beats a clear in the same cycle
    if (posted_flag_set || serr_event) begin
      sig_err_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sig_err_q <= 1'b0;
    end else begin
      sig_err_q <= sig_err_d;
    end
  end

  // Other status bits are owned elsewhere and read as zero here
  always_comb begin
    primary_device_status_out = `HPBAC_PSTS_RESET;
    primary_device_status_out[`HPBAC_PSTS_SIG_ERR_BIT] = sig_err_q;
  end

  // PCI reads toward the hub
  // Upstream writes never learn of a hub master abort, so they need no path here
  hpbac_up_read u_up_read (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .abort_mode_in(abort_mode),
    .up_rd_start_in(up_rd_start_in),
    .hub_rd_valid_in(hub_rd_valid_in),
    .hub_rd_last_in(hub_rd_last_in),
    .hub_rd_data_in(hub_rd_data_in),
    .hub_master_abort_in(hub_master_abort_in),
    .hub_abort_data_in(hub_abort_data_in),
    .pci_rd_valid_out(pci_rd_valid_out),
    .pci_rd_data_out(pci_rd_data_out),
    .pci_target_abort_out(pci_target_abort_out),
    .prefetch_flush_out(prefetch_flush_out),
    .up_rd_busy_out(up_rd_busy_out)
  );

  // Decode never sees the ISA or 16-bit decode bits
  hpbac_decode u_decode (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .vga_en_in(vga_en),
    .pci_addr_in(pci_addr_in),
    .pci_mem_cycle_in(pci_mem_cycle_in),
    .pci_io_cycle_in(pci_io_cycle_in),
    .pci_io_target_hit_in(pci_io_target_hit_in),
    .hub_io_cycle_in(hub_io_cycle_in),
    .usb_io_hit_in(usb_io_hit_in),
    .audio_io_hit_in(audio_io_hit_in),
    .ide_io_hit_in(ide_io_hit_in),
    .pci_mem_claim_out(pci_mem_claim_out),
    .pci_io_claim_out(pci_io_claim_out),
    .hub_io_to_pci_out(hub_io_to_pci_out)
  );
endmodule

// ---- hpbac_checker.sv ----
// Assertion checker bound to the bridge control top
`timescale 1ns/1ps
`include "hpbac_defines.svh"
module hpbac_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ctrl_wr_in,
  input wire logic [7:0] ctrl_wdata_in,
  input wire logic [7:0] ctrl_rdata_out,
  input wire logic [15:0] primary_cmd_in,
  input wire logic [15:0] primary_device_status_out,
  input wire logic pci_serr_n_in,
  input wire logic nmi_to_sysmgmt_in,
  input wire logic sig_err_flag_clr_in,
  input wire logic nmi_out,
  input wire logic system_management_interrupt_out,
  input wire logic hub_req_posted_in,
  input wire logic hub_req_read_in,
  input wire logic pci_master_abort_in,
  input wire logic hub_cmpl_valid_out,
  input wire logic [1:0] hub_cmpl_status_out,
  input wire logic [31:0] hub_cmpl_data_out,
  input wire logic posted_drop_out,
  input wire logic dn_busy_out,
  input wire logic up_rd_busy_out,
  input wire logic hub_master_abort_in,
  input wire logic [31:0] hub_abort_data_in,
  input wire logic pci_rd_valid_out,
  input wire logic [31:0] pci_rd_data_out,
  input wire logic pci_target_abort_out,
  input wire logic prefetch_flush_out,
  input wire logic [31:0] pci_addr_in,
  input wire logic pci_io_cycle_in,
  input wire logic hub_io_cycle_in,
  input wire logic usb_io_hit_in,
  input wire logic audio_io_hit_in,
  input wire logic ide_io_hit_in,
  input wire logic pci_io_claim_out,
  input wire logic hub_io_to_pci_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  ctrl_store_a: assert property (ctrl_wr_in |=> ctrl_rdata_out == ($past(ctrl_wdata_in) & 8'h3E))
    else $error("control byte not stored as written");
  reset_clear_a: assert property (disable iff (1'b0) rst_in |=> ctrl_rdata_out == 8'h00 &&
    primary_device_status_out == 16'h0000) else $error("reset left state behind");
  dn_abort_a: assert property (dn_busy_out && pci_master_abort_in && hub_req_read_in && !hub_req_posted_in
    |=> hub_cmpl_valid_out && hub_cmpl_status_out == (ctrl_rdata_out[5] ? 2'b10 : 2'b01)
    && hub_cmpl_data_out == `HPBAC_ABORT_DATA) else $error("downstream abort completion wrong");
  posted_drop_a: assert property (dn_busy_out && pci_master_abort_in && hub_req_posted_in |=> posted_drop_out
    && !hub_cmpl_valid_out && primary_device_status_out[14] == (($past(primary_device_status_out[14])
    && !$past(sig_err_flag_clr_in)) || (ctrl_rdata_out[5] && ctrl_rdata_out[1])))
    else $error("posted abort handling wrong");
  up_pass_a: assert property (up_rd_busy_out && hub_master_abort_in && !ctrl_rdata_out[5] |=> pci_rd_valid_out
    && pci_rd_data_out == $past(hub_abort_data_in) && !pci_target_abort_out) else $error("abort data not passed");
  up_flush_a: assert property (up_rd_busy_out && hub_master_abort_in && ctrl_rdata_out[5] |=> pci_target_abort_out
    && prefetch_flush_out && !pci_rd_valid_out && !up_rd_busy_out) else $error("upstream target abort wrong");
  vga_io_a: assert property (pci_io_cycle_in && (pci_addr_in inside {[`HPBAC_VGA_IO_LO1:`HPBAC_VGA_IO_HI1],
    [`HPBAC_VGA_IO_LO2:`HPBAC_VGA_IO_HI2]}) |=> !pci_io_claim_out) else $error("VGA port claimed");
  hub_fwd_a: assert property (hub_io_cycle_in && !usb_io_hit_in && !audio_io_hit_in && !ide_io_hit_in
    |=> hub_io_to_pci_out) else $error("hub I/O not forwarded");
  sys_err_a: assert property ($fell(pci_serr_n_in) && ctrl_rdata_out[1] && primary_cmd_in[8] |-> ##[2:4]
    ((nmi_to_sysmgmt_in ? system_management_interrupt_out : nmi_out) && primary_device_status_out[14]))
    else $error("system error not signalled");
endmodule
bind hpbac_top hpbac_checker u_checker (.*);

// ---- hpbac_pci_agent.sv ----
// Far-side PCI target model answering forwarded hub requests
`timescale 1ns/1ps
module hpbac_pci_agent (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic dn_busy_in,
  input wire logic abort_in,
  input wire logic [3:0] dly_in,
  input wire logic [31:0] data_in,
  output logic done_out,
  output logic abort_out,
  output logic [31:0] data_out
);
  // Data toggles outside the answer cycle so stale values never look valid
  initial begin
    done_out = 1'b0;
    abort_out = 1'b0;
    data_out = 32'h0;
    forever begin
      @(negedge clk_in);
      done_out = 1'b0;
      abort_out = 1'b0;
      data_out = ~data_out;
      if (dn_busy_in === 1'b1 && rst_in === 1'b0) begin
        repeat (dly_in) @(negedge clk_in);
        data_out = data_in;
        abort_out = abort_in;
        done_out = !abort_in;
      end
    end
  end
endmodule

// ---- hpbac_top_tb_top.sv ----
// Self-checking bench for the bridge abort and decode control block
`timescale 1ns/1ps
`include "hpbac_defines.svh"
module hpbac_top_tb_top;
  logic clk_in, rst_in, ctrl_wr_in, sig_err_flag_clr_in, pci_serr_n_in, nmi_to_sysmgmt_in, nmi_out;
  logic system_management_interrupt_out, hub_req_start_in, hub_req_posted_in, hub_req_read_in;
  logic pci_cycle_done_in, pci_master_abort_in, hub_cmpl_valid_out, posted_drop_out, dn_busy_out;
  logic up_rd_start_in, hub_rd_valid_in, hub_rd_last_in, hub_master_abort_in, pci_rd_valid_out;
  logic pci_target_abort_out, prefetch_flush_out, up_rd_busy_out, pci_mem_cycle_in, pci_io_cycle_in;
  logic pci_io_target_hit_in, hub_io_cycle_in, usb_io_hit_in, audio_io_hit_in, ide_io_hit_in;
  logic pci_mem_claim_out, pci_io_claim_out, hub_io_to_pci_out, ag_abort;
  logic [7:0] ctrl_wdata_in, ctrl_rdata_out;
  logic [15:0] primary_cmd_in, primary_device_status_out;
  logic [1:0] hub_cmpl_status_out;
  logic [31:0] pci_rd_data_in, hub_cmpl_data_out, hub_rd_data_in, hub_abort_data_in, pci_rd_data_out;
  logic [31:0] pci_addr_in;
  logic [3:0] ag_dly;
  logic [7:0] st [3] = '{8'h02, 8'h22, 8'h20};
  logic [31:0] adr [10] = '{32'hA0000, 32'hBFFFF, 32'h9FFFF, 32'hC0000, 32'h3B0, 32'h3BB, 32'h3BC, 32'h3C0,
    32'h3DF, 32'h3E0};
  int n_fail, total_checks, cyc;
  hpbac_top u_dut (.*);
  hpbac_pci_agent u_agent (.clk_in, .rst_in, .dn_busy_in(dn_busy_out), .abort_in(ag_abort), .dly_in(ag_dly),
    .data_in(32'h5A3C_96E1), .done_out(pci_cycle_done_in), .abort_out(pci_master_abort_in), .data_out(pci_rd_data_in));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Run needs a few hundred cycles; ceiling leaves ample margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  task automatic wr_ctrl(input logic [7:0] val);
    @(negedge clk_in);
    ctrl_wr_in = 1'b1;
    ctrl_wdata_in = val;
    @(negedge clk_in);
    ctrl_wr_in = 1'b0;
  endtask
  task automatic clr_flag();
    sig_err_flag_clr_in = 1'b1;
    @(negedge clk_in);
    sig_err_flag_clr_in = 1'b0;
    @(negedge clk_in);
    check("status_clear", 32'h0, 32'(primary_device_status_out));
  endtask
  task automatic dn_req(input logic posted, input logic rd, input logic abort, input logic mode);
    ag_abort = abort;
    @(negedge clk_in);
    hub_req_start_in = 1'b1;
    hub_req_posted_in = posted;
    hub_req_read_in = rd;
    @(negedge clk_in);
    hub_req_start_in = 1'b0;
    for (int i = 0; i < 20 && dn_busy_out === 1'b1; i++) @(negedge clk_in);
    check("cmpl_valid", 32'(!posted), 32'(hub_cmpl_valid_out));
    check("posted_drop", 32'(posted && abort), 32'(posted_drop_out));
    if (!posted) begin
      check("cmpl_status", abort ? (mode ? 32'h2 : 32'h1) : 32'h0, 32'(hub_cmpl_status_out));
      check("cmpl_data", rd ? (abort ? `HPBAC_ABORT_DATA : 32'h5A3C_96E1) : `HPBAC_ZERO_DATA,
        hub_cmpl_data_out);
    end
  endtask
  task automatic up_rd(input logic abort, input logic mode);
    @(negedge clk_in);
    up_rd_start_in = 1'b1;
    @(negedge clk_in);
    up_rd_start_in = 1'b0;
    hub_master_abort_in = abort;
    hub_rd_valid_in = 1'b1;
    hub_rd_last_in = 1'b1;
    hub_rd_data_in = 32'hA5A5_0F0F;
    hub_abort_data_in = 32'h0BAD_F00D;
    @(negedge clk_in);
    hub_master_abort_in = 1'b0;
    hub_rd_data_in = 32'h5A5A_F0F0;
    check("rd_valid", 32'(!(abort && mode)), 32'(pci_rd_valid_out));
    check("target_abort", 32'(abort && mode), 32'(pci_target_abort_out));
    check("flush", 32'(abort && mode), 32'(prefetch_flush_out));
    if (!(abort && mode))
      check("rd_data", abort ? 32'h0BAD_F00D : 32'hA5A5_0F0F, pci_rd_data_out);
    @(negedge clk_in);
    hub_rd_valid_in = 1'b0;
    if (mode || !abort)
      check("rd_after_end", 32'h0, 32'(pci_rd_valid_out));
  endtask
  task automatic sys_err(input logic route, input logic exp);
    logic [31:0] nn, ns;
    nn = 32'h0;
    ns = 32'h0;
    nmi_to_sysmgmt_in = route;
    @(negedge clk_in);
    pci_serr_n_in = 1'b0;
    repeat (6) begin
      @(negedge clk_in);
      nn = nn + 32'(nmi_out);
      ns = ns + 32'(system_management_interrupt_out);
    end
    pci_serr_n_in = 1'b1;
    check("nmi_count", 32'(exp && !route), nn);
    check("smi_count", 32'(exp && route), ns);
    check("status_flag", 32'(exp) << 14, 32'(primary_device_status_out));
    clr_flag();
  endtask
  initial begin
    {ctrl_wr_in, sig_err_flag_clr_in, nmi_to_sysmgmt_in, hub_req_start_in, hub_req_posted_in, hub_req_read_in} = '0;
    {up_rd_start_in, hub_rd_valid_in, hub_rd_last_in, hub_master_abort_in, pci_mem_cycle_in} = '0;
    {pci_io_cycle_in, pci_io_target_hit_in, hub_io_cycle_in, usb_io_hit_in, audio_io_hit_in, ide_io_hit_in} = '0;
    {ctrl_wdata_in, primary_cmd_in, hub_rd_data_in, hub_abort_data_in, pci_addr_in} = '0;
    pci_serr_n_in = 1'b1;
    ag_abort = 1'b0;
    ag_dly = 4'h1;
    rst_in = 1'b1;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    check("ctrl_reset", 32'h0, 32'(ctrl_rdata_out));
    check("status_reset", 32'h0, 32'(primary_device_status_out));
    foreach (st[k]) begin
      wr_ctrl(st[k]);
      ag_dly = 4'(k);
      check("ctrl_rdata", 32'(st[k] & 8'h3E), 32'(ctrl_rdata_out));
      dn_req(1'b0, 1'b1, 1'b1, st[k][5]);
      dn_req(1'b0, 1'b1, 1'b0, st[k][5]);
      dn_req(1'b0, 1'b0, 1'b1, st[k][5]);
      dn_req(1'b1, 1'b0, 1'b1, st[k][5]);
      check("status_flag", 32'(st[k] == 8'h22) << 14, 32'(primary_device_status_out));
      clr_flag();
      dn_req(1'b1, 1'b0, 1'b0, st[k][5]);
      up_rd(1'b1, st[k][5]);
      up_rd(1'b0, st[k][5]);
    end
    foreach (st[k]) begin
      wr_ctrl(8'h04 << k);
      check("ctrl_rdata", 32'(8'h04 << k), 32'(ctrl_rdata_out));
      foreach (adr[j]) begin
        @(negedge clk_in);
        {pci_mem_cycle_in, pci_io_cycle_in, pci_io_target_hit_in, hub_io_cycle_in} = 4'hF;
        pci_addr_in = adr[j];
        {usb_io_hit_in, audio_io_hit_in, ide_io_hit_in} = 3'(j);
        @(negedge clk_in);
        check("mem_claim", 32'(!(k == 1 && adr[j] inside {[32'hA0000:32'hBFFFF]})), 32'(pci_mem_claim_out));
        check("io_claim", 32'(!(adr[j] inside {[32'h3B0:32'h3BB], [32'h3C0:32'h3DF]})), 32'(pci_io_claim_out));
        check("hub_io_fwd", 32'(j % 8 == 0), 32'(hub_io_to_pci_out));
      end
    end
    wr_ctrl(8'h02);
    primary_cmd_in = 16'h0100;
    sys_err(1'b0, 1'b1);
    sys_err(1'b1, 1'b1);
    primary_cmd_in = 16'h0000;
    sys_err(1'b0, 1'b0);
    wr_ctrl(8'h3E);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    check("ctrl_rereset", 32'h0, 32'(ctrl_rdata_out));
    conclude();
  end
endmodule
